// ==== dv/rxdo_sink_model.sv ====
// Purpose: Baseband-side sink taking words from the receive path
// Assumes: Same clock as the block, one word per ready cycle
// Notes:   Mode 0 prompt, 1 stalled, 2 ready every other cycle
module rxdo_sink_model #(
  parameter int unsigned DW = 12
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic [1:0]    mode_i,
  input  wire logic          vld_i,
  input  wire logic [DW-1:0] i_i,
  input  wire logic [DW-1:0] q_i,
  output logic               rdy_o,
  output int                 count_o,
  output logic [DW-1:0]      last_i_o,
  output logic [DW-1:0]      last_q_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tog_q;

  // Toggle for the slow pattern, free running
  always_ff @(posedge sys_clk_i) begin
    tog_q <= rst_n_i && !tog_q;
  end

  // Ready low in reset so nothing is taken before release
  assign rdy_o = rst_n_i && (mode_i == 2'h0 || (mode_i == 2'h2 && tog_q));

  // Record every accepted word
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      count_o <= 0;
    end else if (vld_i && rdy_o) begin
      count_o  <= count_o + 1;
      last_i_o <= i_i;
      last_q_o <= q_i;
    end
  end
endmodule : rxdo_sink_model

// ==== dv/rxdo_top_checker.sv ====
// Purpose: Port-level checks on the receive path top
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into every top instance
module rxdo_top_checker #(
  parameter int unsigned DW = 12
) (
  input wire logic          sys_clk_i,
  input wire logic          rst_n_i,
  input wire logic          reg_wr_i,
  input wire logic          reg_rd_i,
  input wire logic [7:0]    reg_addr_i,
  input wire logic [7:0]    reg_wdata_i,
  input wire logic [7:0]    reg_rdata_o,
  input wire logic          tx_lock_i,
  input wire logic          rx_lock_i,
  input wire logic          out_vld_o,
  input wire logic [DW-1:0] out_i_o,
  input wire logic [DW-1:0] out_q_o,
  input wire logic          out_rdy_i,
  input wire logic [9:0]    i_gain_trim_word_o,
  input wire logic          single_conv_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] tx_hist_q, rx_hist_q;
  logic       upd_q;
  logic [7:0] off_wd_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Lock history, so a read is judged only on settled levels
  always_ff @(posedge sys_clk_i) begin
    tx_hist_q <= {tx_hist_q[2:0], tx_lock_i};
    rx_hist_q <= {rx_hist_q[2:0], rx_lock_i};
  end

  // Update writes and last offset data seen
  always_ff @(posedge sys_clk_i) begin
    upd_q <= reg_wr_i && reg_addr_i == rxdo_pkg::ADDR_UPDATE && reg_wdata_i[0];
    if (reg_wr_i && reg_addr_i == rxdo_pkg::ADDR_OFFSET) begin
      off_wd_q <= reg_wdata_i;
    end
  end

  property p_rd_hold;
    $changed(reg_rdata_o) |-> $past(reg_rd_i);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");

  property p_unmapped;
    reg_rd_i && reg_addr_i == 8'h33 |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_lock_rd;
    reg_rd_i && reg_addr_i == rxdo_pkg::ADDR_LOCK_STAT &&
    tx_hist_q inside {4'h0, 4'hF} && rx_hist_q inside {4'h0, 4'hF}
    |=> reg_rdata_o == {6'h00, $past(tx_lock_i, 2), $past(rx_lock_i, 2)};
  endproperty
  a_lock_rd: assert property (p_lock_rd)
    else $error("lock status read wrong");

  property p_settings_hold;
    $changed({i_gain_trim_word_o, single_conv_o}) |-> upd_q;
  endproperty
  a_settings_hold: assert property (p_settings_hold)
    else $error("active setting moved without update");

  property p_update_rise;
    upd_q ##2 upd_q |-> $stable({i_gain_trim_word_o, single_conv_o});
  endproperty
  a_update_rise: assert property (p_update_rise)
    else $error("repeated update bit applied again");

  property p_single_dup;
    single_conv_o && out_vld_o |-> out_i_o == out_q_o;
  endproperty
  a_single_dup: assert property (p_single_dup)
    else $error("single mode lanes differ");

  property p_out_hold;
    out_vld_o && !out_rdy_i |=>
      out_vld_o && $stable(out_i_o) && $stable(out_q_o);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output word dropped while stalled");

  property p_offset_rd;
    reg_wr_i && reg_addr_i == rxdo_pkg::ADDR_CHAN_SEL &&
    reg_wdata_i == rxdo_pkg::SEL_Q ##2
    reg_wr_i && reg_addr_i == rxdo_pkg::ADDR_OFFSET ##2
    reg_rd_i && reg_addr_i == rxdo_pkg::ADDR_OFFSET
    |=> reg_rdata_o == {{2{off_wd_q[5]}}, off_wd_q[5:0]};
  endproperty
  a_offset_rd: assert property (p_offset_rd)
    else $error("offset readback not sign extended");
endmodule : rxdo_top_checker

bind rxdo_top rxdo_top_checker #(.DW(DW)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .tx_lock_i(tx_lock_i), .rx_lock_i(rx_lock_i),
  .out_vld_o(out_vld_o), .out_i_o(out_i_o), .out_q_o(out_q_o),
  .out_rdy_i(out_rdy_i), .i_gain_trim_word_o(i_gain_trim_word_o),
  .single_conv_o(single_conv_o));

// ==== dv/rxdo_top_test.sv ====
// Purpose: Register and stream tests of the receive path top
// Assumes: Inputs driven 1 ns after the rising edge
// Notes:   Filter checked on a settled constant stream
module rxdo_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned DW = 12;
  logic          sys_clk_i = 1'b0;
  logic          rst_n_i = 1'b0;
  logic          reg_wr_i = 1'b0, reg_rd_i = 1'b0, adc_vld_i = 1'b0;
  logic          tx_lock_i = 1'b0, rx_lock_i = 1'b0;
  logic [7:0]    reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [DW-1:0] adc_i_i = '0, adc_q_i = '0, out_i_o, out_q_o, lst_i, lst_q;
  logic          out_vld_o, out_rdy_i, in_rdy_o, fine_o, ical_o, qcal_o;
  logic          single_o;
  logic [9:0]    itrim_o, qtrim_o;
  logic [1:0]    mode = 2'h0;
  logic          saw_full = 1'b0;
  int            n_fail = 0, cmp_count = 0, base = 0, rx_cnt;

  // Free-running 50 MHz clock
  always #10 sys_clk_i = ~sys_clk_i;

  rxdo_top #(.DW(DW)) dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .tx_lock_i(tx_lock_i), .rx_lock_i(rx_lock_i),
    .adc_vld_i(adc_vld_i), .adc_i_i(adc_i_i), .adc_q_i(adc_q_i),
    .out_vld_o(out_vld_o), .out_i_o(out_i_o), .out_q_o(out_q_o),
    .out_rdy_i(out_rdy_i), .in_rdy_o(in_rdy_o),
    .i_gain_trim_word_o(itrim_o), .q_gain_trim_word_o(qtrim_o),
    .gain_cal_fine_step_o(fine_o), .i_cal_converter_enable_o(ical_o),
    .q_cal_converter_enable_o(qcal_o), .single_conv_o(single_o));

  rxdo_sink_model #(.DW(DW)) u_sink (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .mode_i(mode),
    .vld_i(out_vld_o), .i_i(out_i_o), .q_i(out_q_o), .rdy_o(out_rdy_i),
    .count_o(rx_cnt), .last_i_o(lst_i), .last_q_o(lst_q));

  // Verdict and end of run
  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Step past n edges, landing just after the last
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick

  // Idle cycle after each access keeps strobes single pulses
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick(1);
    reg_rd_i = 1'b0;
    chk({8'h00, reg_rdata_o}, {8'h00, exp});
    tick(1);
  endtask : rd_chk

  // Update needs a fresh rising edge of bit 0
  task automatic upd();
    wr(rxdo_pkg::ADDR_UPDATE, 8'h00);
    wr(rxdo_pkg::ADDR_UPDATE, 8'h01);
  endtask : upd

  task automatic send(input logic [DW-1:0] si, input logic [DW-1:0] sq,
                      input int n);
    base = rx_cnt;
    adc_i_i = si;
    adc_q_i = sq;
    adc_vld_i = 1'b1;
    repeat (n) begin
      tick(1);
      if (in_rdy_o === 1'b0) saw_full = 1'b1;
    end
    adc_vld_i = 1'b0;
    tick(1);
  endtask : send

  // Bounded wait for n words, then an exact count
  task automatic drain(input int n);
    for (int k = 0; k < 400 && rx_cnt - base < n; k++) tick(1);
    if (rx_cnt - base < n) begin
      n_fail++;
      wrap_up();
    end
    tick(8);
    chk(16'(rx_cnt - base), 16'(n));
  endtask : drain

  initial begin
    tick(8);
    rst_n_i = 1'b1;
    tick(1);
    chk({fine_o, ical_o, qcal_o, single_o, out_vld_o, 1'b0, itrim_o},
        16'h0000);
    foreach (rxdo_pkg::ODD_TAPS[k]) rd_chk(8'(k * 8'h11 + 8'h7E), 8'h00);
    rd_chk(8'h33, 8'h00);
    for (int k = 1; k < 3; k++) begin
      {tx_lock_i, rx_lock_i} = k[1:0];
      tick(6);
      rd_chk(rxdo_pkg::ADDR_LOCK_STAT, 8'(k));
    end
    // Trim words staged, then made active
    wr(rxdo_pkg::ADDR_TRIM_CTRL, 8'h60);
    wr(rxdo_pkg::ADDR_I_TRIM_HI, 8'hA5);
    wr(rxdo_pkg::ADDR_I_TRIM_LO, 8'h05);
    wr(rxdo_pkg::ADDR_Q_TRIM_HI, 8'h3C);
    wr(rxdo_pkg::ADDR_Q_TRIM_LO, 8'h02);
    chk({6'h00, itrim_o}, 16'h0000);
    upd();
    chk({6'h00, itrim_o}, 16'h0296);
    chk({6'h00, qtrim_o}, 16'h00F1);
    chk({13'h0000, fine_o, ical_o, qcal_o}, 16'h0006);
    wr(rxdo_pkg::ADDR_I_TRIM_HI, 8'h00);
    wr(rxdo_pkg::ADDR_UPDATE, 8'h01);
    wr(rxdo_pkg::ADDR_UPDATE, 8'h01);
    chk({6'h00, itrim_o}, 16'h0296);
    wr(rxdo_pkg::ADDR_TRIM_CTRL, 8'h00);
    upd();
    chk({5'h00, fine_o, itrim_o}, 16'h0000);
    // Offsets per channel, select cleared ignores writes
    wr(rxdo_pkg::ADDR_CHAN_SEL, rxdo_pkg::SEL_I);
    wr(rxdo_pkg::ADDR_OFFSET, 8'h06);
    wr(rxdo_pkg::ADDR_CHAN_SEL, rxdo_pkg::SEL_Q);
    wr(rxdo_pkg::ADDR_OFFSET, 8'hFE);
    rd_chk(rxdo_pkg::ADDR_OFFSET, 8'hFE);
    wr(rxdo_pkg::ADDR_CHAN_SEL, rxdo_pkg::SEL_NORMAL);
    wr(rxdo_pkg::ADDR_OFFSET, 8'h1F);
    wr(rxdo_pkg::ADDR_CHAN_SEL, rxdo_pkg::SEL_I);
    rd_chk(rxdo_pkg::ADDR_OFFSET, 8'h06);
    wr(rxdo_pkg::ADDR_PATH_CTRL, 8'h00);
    upd();
    send(12'h064, 12'h0C8, 1);
    drain(1);
    chk({4'h0, lst_i}, 16'h006A);
    chk({4'h0, lst_q}, 16'h00C6);
    // Decimation on a settled stream, sink half rate
    mode = 2'h2;
    wr(rxdo_pkg::ADDR_PATH_CTRL, 8'h01);
    upd();
    send(12'h05E, 12'h0CA, 60);
    drain(30);
    chk({4'h0, lst_i}, 16'h0064);
    chk({4'h0, lst_q}, 16'h00C8);
    // Single converter keeping Q
    mode = 2'h0;
    wr(rxdo_pkg::ADDR_PATH_CTRL, 8'h06);
    upd();
    send(12'h00A, 12'h12E, 1);
    drain(1);
    chk({3'h0, single_o, lst_i}, 16'h112C);
    chk({4'h0, lst_q}, 16'h012C);
    // Single converter keeping I, with its +6 offset on both lanes
    wr(rxdo_pkg::ADDR_PATH_CTRL, 8'h02);
    upd();
    send(12'h00A, 12'h12E, 1);
    drain(1);
    chk({4'h0, lst_q}, 16'h0010);
    chk({4'h0, lst_i}, 16'h0010);
    // Fill the buffer against a stalled sink, then empty it
    wr(rxdo_pkg::ADDR_PATH_CTRL, 8'h00);
    upd();
    mode = 2'h1;
    send(12'h001, 12'h002, 24);
    chk({15'h0000, saw_full}, 16'h0001);
    mode = 2'h0;
    for (int k = 0; k < 200 && out_vld_o !== 1'b0; k++) tick(1);
    tick(4);
    chk({14'h0000, out_vld_o, in_rdy_o}, 16'h0001);
    chk(16'(rx_cnt - base >= rxdo_pkg::FIFO_DEPTH), 16'h0001);
    wrap_up();
  end
endmodule : rxdo_top_test

// ==== hdl/rxdo_fifo.sv ====
// Purpose: Parameterised synchronous FIFO
// Assumes: Same clock on both sides
// Notes:   Full and empty exact; drain side may stall
module rxdo_fifo #(
  parameter int unsigned W     = 24,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  rxdo_stream_if.snk in_s,
  rxdo_stream_if.src out_s
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Handshakes on both sides
  assign in_s.ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = mem_q[rd_q];
  assign push = in_s.valid & in_s.ready;
  assign pop  = out_s.valid & out_s.ready;

  // Storage needs no reset
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_s.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : rxdo_fifo

// ==== hdl/rxdo_halfband.sv ====
// Purpose: Bypassable 2x half-band decimator for one channel
// Assumes: One input sample per in_vld pulse
// Notes:   Folded odd taps, centre tap as a shift
module rxdo_halfband #(
  parameter int unsigned DW = 12
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          dec_en_i,
  input  wire logic          in_vld_i,
  input  wire logic [DW-1:0] in_i,
  output logic               out_vld_o,
  output logic [DW-1:0]      out_o
);
  localparam int unsigned N  = rxdo_pkg::NUM_TAPS;
  localparam int unsigned AW = DW + rxdo_pkg::COEF_W + 6;
  logic signed [DW-1:0] tap_q [N];
  logic                 phase_q;
  logic signed [AW-1:0] acc;

  // Delay line of input samples
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < N; k++) tap_q[k] <= '0;
    end else if (in_vld_i) begin
      tap_q[0] <= in_i;
      for (int k = 1; k < N; k++) tap_q[k] <= tap_q[k-1];
    end
  end

  // Odd taps folded by symmetry; even taps are zero except centre
  always_comb begin
    acc = AW'(tap_q[21]) <<< rxdo_pkg::COEF_SHIFT - 1; // RULE_04
    for (int k = 0; k < rxdo_pkg::NUM_ODD; k++) begin
      acc = acc + (AW'(tap_q[2*k]) + AW'(tap_q[N-1-2*k]))
                * AW'(rxdo_pkg::ODD_TAPS[k]); // RULE_03
    end
  end

  // Keep one result in two; bypass passes every sample
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      phase_q   <= 1'b0;
      out_vld_o <= 1'b0;
      out_o     <= '0;
    end else begin
      out_vld_o <= 1'b0;
      if (in_vld_i) phase_q <= ~phase_q;
      if (!dec_en_i && in_vld_i) begin // RULE_01
        out_vld_o <= 1'b1;
        out_o     <= in_i;
      end else if (dec_en_i && in_vld_i && phase_q) begin // RULE_02
        out_vld_o <= 1'b1;
        out_o     <= DW'(acc >>> rxdo_pkg::COEF_SHIFT); // RULE_05
      end
    end
  end
endmodule : rxdo_halfband

// ==== hdl/rxdo_pkg.sv ====
// Purpose: Shared constants for the receive decimation and offset path
// Assumes: 8-bit register port, 12-bit converter samples
// Notes:   Register offsets, field positions, reset values and taps
// What this block does
// RULE_01 - I and Q each have a bypassable rate-halving low-pass stage.
// RULE_02 - With decimation on, one output sample per two inputs, half-band.
// RULE_03 - Symmetric 43-tap filter, odd taps listed, centre tap 16384.
// RULE_04 - Unlisted even taps other than the centre are zero.
// RULE_05 - Response gives over 7 dB stop-band rejection over 40% of rate.
// RULE_06 - Each channel adds its own signed 6-bit offset at the sample LSBs.
// RULE_07 - Channel select written first, then offset goes to that channel only.
// RULE_08 - Select 0x01 is I, 0x02 is Q, 0x00 returns normal addressing.
// RULE_09 - Offset is two's complement, 0xFE means minus two LSBs.
// RULE_10 - Rising edge of update bit copies staged settings to active set.
// RULE_11 - I trim word is 10 bits: 0x7F holds 9:2, 0x80 bits 2:1 hold 1:0.
// RULE_12 - Q trim word is 10 bits: 0x81 holds 9:2, 0x82 bits 2:1 hold 1:0.
// RULE_13 - Trim words have no effect unless global calibration enable is set.
// RULE_14 - Fine step control halves the trim step size.
// RULE_15 - Bit 0 of each low trim register enables that channel calibrator.
// RULE_16 - Register 0x84 reports transmit lock bit 1, receive lock bit 0.
// RULE_17 - One converter may power down with output in single-channel mode.
package rxdo_pkg;
  localparam logic [7:0] ADDR_CHAN_SEL  = 8'h05;
  localparam logic [7:0] ADDR_OFFSET    = 8'h10;
  localparam logic [7:0] ADDR_TRIM_CTRL = 8'h7E;
  localparam logic [7:0] ADDR_I_TRIM_HI = 8'h7F;
  localparam logic [7:0] ADDR_I_TRIM_LO = 8'h80;
  localparam logic [7:0] ADDR_Q_TRIM_HI = 8'h81;
  localparam logic [7:0] ADDR_Q_TRIM_LO = 8'h82;
  localparam logic [7:0] ADDR_LOCK_STAT = 8'h84;
  localparam logic [7:0] ADDR_PATH_CTRL = 8'h90;
  localparam logic [7:0] ADDR_UPDATE    = 8'hFF;
  localparam logic [7:0] SEL_NORMAL     = 8'h00;
  localparam logic [7:0] SEL_I          = 8'h01;
  localparam logic [7:0] SEL_Q          = 8'h02;
  localparam int unsigned BIT_TRIM_EN   = 6;
  localparam int unsigned BIT_TRIM_FINE = 5;
  localparam int unsigned BIT_CAL_EN    = 0;
  localparam int unsigned BIT_UPDATE    = 0;
  localparam int unsigned BIT_TX_LOCK   = 1;
  localparam int unsigned BIT_RX_LOCK   = 0;
  localparam int unsigned BIT_DEC_EN    = 0;
  localparam int unsigned BIT_SINGLE    = 1;
  localparam int unsigned BIT_SINGLE_Q  = 2;
  localparam logic [7:0] RST_REG        = 8'h00;
  localparam int unsigned OFFSET_W      = 6;
  localparam int unsigned TRIM_W        = 10;
  localparam int unsigned NUM_TAPS      = 43;
  localparam int unsigned NUM_ODD       = 11;
  localparam int unsigned COEF_W        = 16;
  localparam int unsigned COEF_SHIFT    = 15;
  localparam logic signed [COEF_W-1:0] CENTRE_TAP = 16'sd16384;
  localparam logic signed [COEF_W-1:0] ODD_TAPS [NUM_ODD] = '{
    16'sd12, -16'sd32, 16'sd72, -16'sd140, 16'sd252, -16'sd422,
    16'sd682, -16'sd1086, 16'sd1778, -16'sd3284, 16'sd10364};
  localparam int unsigned FIFO_DEPTH    = 16;
endpackage : rxdo_pkg

// ==== hdl/rxdo_stream_if.sv ====
// Purpose: Valid/ready carrier between filter stages and output FIFO
// Assumes: Single clock
// Notes:   Word carries I and Q packed
interface rxdo_stream_if #(parameter int unsigned W = 24);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : rxdo_stream_if

// ==== hdl/rxdo_top.sv ====
// Purpose: Receive decimation, offset and trim register path
// Assumes: Register port writes and ADC samples on sys_clk_i
// Notes:   Staged settings become active on update rising edge
module rxdo_top #(
  parameter int unsigned DW = 12
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  input  wire logic [7:0]    reg_addr_i,
  input  wire logic [7:0]    reg_wdata_i,
  output logic [7:0]         reg_rdata_o,
  input  wire logic          tx_lock_i,
  input  wire logic          rx_lock_i,
  input  wire logic          adc_vld_i,
  input  wire logic [DW-1:0] adc_i_i,
  input  wire logic [DW-1:0] adc_q_i,
  output logic               out_vld_o,
  output logic [DW-1:0]      out_i_o,
  output logic [DW-1:0]      out_q_o,
  input  wire logic          out_rdy_i,
  output logic               in_rdy_o,
  output logic [9:0]         i_gain_trim_word_o,
  output logic [9:0]         q_gain_trim_word_o,
  output logic               gain_cal_fine_step_o,
  output logic               i_cal_converter_enable_o,
  output logic               q_cal_converter_enable_o,
  output logic               single_conv_o
);
  localparam int unsigned OW = rxdo_pkg::OFFSET_W;
  // Staged register set
  logic [7:0] chan_sel_q;
  logic [7:0] trim_ctrl_q;
  logic [7:0] i_hi_q;
  logic [7:0] i_lo_q;
  logic [7:0] q_hi_q;
  logic [7:0] q_lo_q;
  logic [7:0] path_q;
  logic [7:0] upd_q;
  logic [OW-1:0] i_channel_offset_q;
  logic [OW-1:0] q_channel_offset_q;
  // Active set
  logic [OW-1:0] act_i_off_q;
  logic [OW-1:0] act_q_off_q;
  logic          act_dec_q;
  logic          act_single_q;
  logic          act_single_q_q;
  logic          act_trim_en_q;
  // Lock synchronisers
  logic [1:0] tx_lock_sync_q;
  logic [1:0] rx_lock_sync_q;
  logic       upd_rise;
  logic       wr_upd;

  // Samples after offset and decimation
  logic          hb_i_vld;
  logic          hb_q_vld;
  logic [DW-1:0] hb_i;
  logic [DW-1:0] hb_q;
  logic [DW-1:0] off_i_d;
  logic [DW-1:0] off_q_d;

  rxdo_stream_if #(.W(2*DW)) fifo_in ();
  rxdo_stream_if #(.W(2*DW)) fifo_out ();

  // Register writes; offset goes only to the selected channel
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      chan_sel_q         <= rxdo_pkg::RST_REG;
      trim_ctrl_q        <= rxdo_pkg::RST_REG;
      i_hi_q             <= rxdo_pkg::RST_REG;
      i_lo_q             <= rxdo_pkg::RST_REG;
      q_hi_q             <= rxdo_pkg::RST_REG;
      q_lo_q             <= rxdo_pkg::RST_REG;
      path_q             <= rxdo_pkg::RST_REG;
      upd_q              <= rxdo_pkg::RST_REG;
      i_channel_offset_q <= '0;
      q_channel_offset_q <= '0;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        rxdo_pkg::ADDR_CHAN_SEL:  chan_sel_q  <= reg_wdata_i; // RULE_08
        rxdo_pkg::ADDR_TRIM_CTRL: trim_ctrl_q <= reg_wdata_i;
        rxdo_pkg::ADDR_I_TRIM_HI: i_hi_q      <= reg_wdata_i; // RULE_11
        rxdo_pkg::ADDR_I_TRIM_LO: i_lo_q      <= reg_wdata_i; // RULE_11
        rxdo_pkg::ADDR_Q_TRIM_HI: q_hi_q      <= reg_wdata_i; // RULE_12
        rxdo_pkg::ADDR_Q_TRIM_LO: q_lo_q      <= reg_wdata_i; // RULE_12
        rxdo_pkg::ADDR_PATH_CTRL: path_q      <= reg_wdata_i;
        rxdo_pkg::ADDR_UPDATE:    upd_q       <= reg_wdata_i;
        rxdo_pkg::ADDR_OFFSET: begin
          if (chan_sel_q == rxdo_pkg::SEL_I) begin // RULE_07
            i_channel_offset_q <= reg_wdata_i[OW-1:0];
          end
          if (chan_sel_q == rxdo_pkg::SEL_Q) begin // RULE_07
            q_channel_offset_q <= reg_wdata_i[OW-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Update fires on the 0-to-1 change of the written bit
  assign wr_upd   = reg_wr_i && (reg_addr_i == rxdo_pkg::ADDR_UPDATE);
  assign upd_rise = wr_upd && reg_wdata_i[rxdo_pkg::BIT_UPDATE]
                    && !upd_q[rxdo_pkg::BIT_UPDATE]; // RULE_10

  // Copy staged configuration into the active set
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      act_i_off_q              <= '0;
      act_q_off_q              <= '0;
      act_dec_q                <= 1'b0;
      act_single_q             <= 1'b0;
      act_single_q_q           <= 1'b0;
      act_trim_en_q            <= 1'b0;
      i_gain_trim_word_o       <= '0;
      q_gain_trim_word_o       <= '0;
      gain_cal_fine_step_o     <= 1'b0;
      i_cal_converter_enable_o <= 1'b0;
      q_cal_converter_enable_o <= 1'b0;
      single_conv_o            <= 1'b0;
    end else if (upd_rise) begin // RULE_10
      act_i_off_q    <= i_channel_offset_q;
      act_q_off_q    <= q_channel_offset_q;
      act_dec_q      <= path_q[rxdo_pkg::BIT_DEC_EN];
      act_single_q   <= path_q[rxdo_pkg::BIT_SINGLE];
      act_single_q_q <= path_q[rxdo_pkg::BIT_SINGLE_Q];
      single_conv_o  <= path_q[rxdo_pkg::BIT_SINGLE]; // RULE_17
      act_trim_en_q  <= trim_ctrl_q[rxdo_pkg::BIT_TRIM_EN];
      // Trim words forced to zero while global enable is clear
      i_gain_trim_word_o <= trim_ctrl_q[rxdo_pkg::BIT_TRIM_EN]
                            ? {i_hi_q, i_lo_q[2:1]} : '0; // RULE_13
      q_gain_trim_word_o <= trim_ctrl_q[rxdo_pkg::BIT_TRIM_EN]
                            ? {q_hi_q, q_lo_q[2:1]} : '0; // RULE_13
      gain_cal_fine_step_o <= trim_ctrl_q[rxdo_pkg::BIT_TRIM_EN]
                            & trim_ctrl_q[rxdo_pkg::BIT_TRIM_FINE]; // RULE_14
      i_cal_converter_enable_o <= i_lo_q[rxdo_pkg::BIT_CAL_EN]; // RULE_15
      q_cal_converter_enable_o <= q_lo_q[rxdo_pkg::BIT_CAL_EN]; // RULE_15
    end
  end

  // Lock flags come from other clocks
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      tx_lock_sync_q <= '0;
      rx_lock_sync_q <= '0;
    end else begin
      tx_lock_sync_q <= {tx_lock_sync_q[0], tx_lock_i};
      rx_lock_sync_q <= {rx_lock_sync_q[0], rx_lock_i};
    end
  end

  // Read mux; unmapped addresses read zero
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        rxdo_pkg::ADDR_CHAN_SEL:  reg_rdata_o <= chan_sel_q;
        rxdo_pkg::ADDR_TRIM_CTRL: reg_rdata_o <= trim_ctrl_q;
        rxdo_pkg::ADDR_I_TRIM_HI: reg_rdata_o <= i_hi_q;
        rxdo_pkg::ADDR_I_TRIM_LO: reg_rdata_o <= {5'h00, i_lo_q[2:0]};
        rxdo_pkg::ADDR_Q_TRIM_HI: reg_rdata_o <= q_hi_q;
        rxdo_pkg::ADDR_Q_TRIM_LO: reg_rdata_o <= {5'h00, q_lo_q[2:0]};
        rxdo_pkg::ADDR_PATH_CTRL: reg_rdata_o <= path_q;
        rxdo_pkg::ADDR_UPDATE:    reg_rdata_o <= {7'h00, upd_q[0]};
        rxdo_pkg::ADDR_OFFSET: begin
          // Reads back Q when the select register holds SEL_Q, I for any other select value
          if (chan_sel_q == rxdo_pkg::SEL_Q) begin
            reg_rdata_o <= {{(8-OW){q_channel_offset_q[OW-1]}},
                            q_channel_offset_q};
          end else begin
            reg_rdata_o <= {{(8-OW){i_channel_offset_q[OW-1]}},
                            i_channel_offset_q};
          end
        end
        rxdo_pkg::ADDR_LOCK_STAT: begin
          reg_rdata_o <= '0;
          reg_rdata_o[rxdo_pkg::BIT_TX_LOCK] <= tx_lock_sync_q[1]; // RULE_16
          reg_rdata_o[rxdo_pkg::BIT_RX_LOCK] <= rx_lock_sync_q[1]; // RULE_16
        end
        default: reg_rdata_o <= '0;
      endcase
    end
  end

  // Signed offset added at the sample LSBs, saturating nothing
  assign off_i_d = adc_i_i + {{(DW-OW){act_i_off_q[OW-1]}},
                              act_i_off_q}; // RULE_06 RULE_09
  assign off_q_d = adc_q_i + {{(DW-OW){act_q_off_q[OW-1]}},
                              act_q_off_q}; // RULE_06 RULE_09

  // Samples accepted only while the FIFO has space
  logic ch_vld;
  assign ch_vld = adc_vld_i & fifo_in.ready;

  rxdo_halfband #(.DW(DW)) u_hb_i (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .dec_en_i  (act_dec_q),
    .in_vld_i  (ch_vld),
    .in_i      (off_i_d),
    .out_vld_o (hb_i_vld),
    .out_o     (hb_i)
  );

  rxdo_halfband #(.DW(DW)) u_hb_q (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .dec_en_i  (act_dec_q),
    .in_vld_i  (ch_vld),
    .in_i      (off_q_d),
    .out_vld_o (hb_q_vld),
    .out_o     (hb_q)
  );

  // Single-converter mode copies the kept channel onto both lanes
  always_comb begin
    fifo_in.valid = hb_i_vld & hb_q_vld;
    if (act_single_q && act_single_q_q) begin // RULE_17
      fifo_in.data = {hb_q, hb_q};
    end else if (act_single_q) begin
      fifo_in.data = {hb_i, hb_i};
    end else begin
      fifo_in.data = {hb_i, hb_q};
    end
  end

  rxdo_fifo #(.W(2*DW), .DEPTH(rxdo_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .in_s      (fifo_in),
    .out_s     (fifo_out)
  );

  // Registered output stage, one word held until taken
  assign fifo_out.ready = !out_vld_o || out_rdy_i;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      out_vld_o <= 1'b0;
      out_i_o   <= '0;
      out_q_o   <= '0;
      in_rdy_o  <= 1'b0;
    end else begin
      in_rdy_o <= fifo_in.ready;
      if (fifo_out.ready) begin
        out_vld_o <= fifo_out.valid;
        out_i_o   <= fifo_out.data[2*DW-1:DW];
        out_q_o   <= fifo_out.data[DW-1:0];
      end
    end
  end
endmodule : rxdo_top
